// ---- logic/ksc_pkg.sv ----
// constants shared by the knock processor serial control logic
// assumes a single system clock; serial pins arrive already synchronous
package ksc_pkg;

  // ---------------------------------------------------------------
  // serial word framing
  // ---------------------------------------------------------------
  localparam int unsigned WORD_BITS = 8;
  localparam logic [3:0] WORD_BITS_CNT = 4'h8;
  localparam logic [3:0] CNT_OVER = 4'h9;   // saturation mark for overlong words
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // ---------------------------------------------------------------
  // command word layout: class in the top two bits, payload below
  // ---------------------------------------------------------------
  localparam int unsigned CMD_HI = 7;
  localparam int unsigned CMD_LO = 6;
  localparam int unsigned PAY_HI = 5;
  localparam int unsigned PAY_LO = 0;
  localparam int unsigned HIZ_BIT = 0;      // prescaler word lsb: 1 floats the output unless in diagnostic mode
  localparam int unsigned CHAN_BIT = 0;

  localparam logic [1:0] CMD_PRESCALER = 2'h0;
  localparam logic [1:0] CMD_CHANNEL = 2'h1;
  localparam logic [1:0] CMD_GAIN = 2'h2;
  localparam logic [1:0] CMD_FILTER = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_WORD = 8'h00;
  localparam logic [5:0] RST_PAYLOAD = 6'h00;
  localparam logic RST_CHANNEL = 1'b0;
  localparam logic RST_HIZ = 1'b0;

  // link phase
  typedef enum logic [0:0] {
    ksc_idle,
    ksc_shift
  } ksc_link_type;

endpackage : ksc_pkg

// ---- logic/ksc_serial_ctrl.sv ----
// serial control port and mode logic of a two-channel knock signal processor
// assumes chip select, serial clock, data and mode pins are synchronous to i_clk_sys
// and that the serial clock is far slower than the system clock
`timescale 1ns/100ps

module ksc_serial_ctrl #(
  parameter int unsigned INTEG_W = 10
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_int_hold,
  input wire logic i_test_n,
  input wire logic [INTEG_W-1:0] i_integrator_level,
  output logic o_so,
  output logic o_so_oe,
  output logic o_channel_sel,
  output logic o_integrate_mode,
  output logic [INTEG_W-1:0] o_integrator_buffered_output,
  output logic o_diag_mode,
  output logic [5:0] o_prescaler_code,
  output logic o_prescaler_hiz,
  output logic [5:0] o_gain_code,
  output logic [5:0] o_filter_code,
  output logic o_word_applied,
  output logic o_frame_error
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ksc_pkg::ksc_link_type link;
    logic sck_prev;
    logic cs_prev;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [7:0] last_word;
    logic so;
    logic so_oe;
    logic channel;
    logic integrate;
    logic [INTEG_W-1:0] held;
    logic diag;
    logic [5:0] prescaler;
    logic hiz;
    logic [5:0] gain;
    logic [5:0] filter;
    logic applied;
    logic frame_err;
  } ksc_state_type;

  ksc_state_type st;
  ksc_state_type next_st;

  // edge terms; pins are already synchronous so one stage of history suffices
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic selected;
  logic word_ok;
  logic [1:0] cmd;
  logic [5:0] payload;

  assign selected = ~i_cs_n;
  assign sck_fall = st.sck_prev & ~i_sck & selected;
  assign cs_fall = st.cs_prev & ~i_cs_n;
  assign cs_rise = ~st.cs_prev & i_cs_n;
  assign word_ok = (st.bit_cnt == ksc_pkg::WORD_BITS_CNT);
  assign cmd = st.shift_in[ksc_pkg::CMD_HI:ksc_pkg::CMD_LO];
  assign payload = st.shift_in[ksc_pkg::PAY_HI:ksc_pkg::PAY_LO];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.sck_prev = i_sck;
    next_st.cs_prev = i_cs_n;
    next_st.applied = 1'b0;
    next_st.frame_err = 1'b0;

    // test pin low means diagnostic mode; the pad pull-up makes open read high
    next_st.diag = ~i_test_n;

    // integrate while high, hold while low
    next_st.integrate = i_int_hold;
    if (i_int_hold) begin
      next_st.held = i_integrator_level;
    end else begin
      next_st.held = st.held;
    end

    // serial link sequencing
    case (st.link)
      ksc_pkg::ksc_idle: begin
        if (cs_fall) begin
          next_st.link = ksc_pkg::ksc_shift;
          next_st.bit_cnt = ksc_pkg::CNT_ZERO;
          // echo the last accepted word so the host can read settings back
          next_st.shift_out = st.last_word;
        end
      end
      ksc_pkg::ksc_shift: begin
        if (sck_fall) begin
          next_st.shift_in = {st.shift_in[ksc_pkg::WORD_BITS-2:0], i_si};
          next_st.shift_out = {st.shift_out[ksc_pkg::WORD_BITS-2:0], 1'b0};
          // saturate so an overlong word is still recognised as wrong
          if (st.bit_cnt != ksc_pkg::CNT_OVER) begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end
        end
        if (cs_rise) begin
          next_st.link = ksc_pkg::ksc_idle;
          if (word_ok) begin
            next_st.applied = 1'b1;
            next_st.last_word = st.shift_in;
            case (cmd)
              ksc_pkg::CMD_PRESCALER: begin
                next_st.prescaler = payload;
                next_st.hiz = st.shift_in[ksc_pkg::HIZ_BIT];
              end
              ksc_pkg::CMD_CHANNEL: begin
                next_st.channel = st.shift_in[ksc_pkg::CHAN_BIT];
              end
              ksc_pkg::CMD_GAIN: begin
                next_st.gain = payload;
              end
              ksc_pkg::CMD_FILTER: begin
                next_st.filter = payload;
              end
              default: begin
                next_st.gain = st.gain;
              end
            endcase
          end else begin
            // short or long words are dropped whole, never half applied
            next_st.frame_err = 1'b1;
          end
        end
      end
      default: begin
        next_st.link = ksc_pkg::ksc_idle;
      end
    endcase

    // output data bit; its drive enable decides whether the host sees it
    next_st.so = next_st.shift_out[ksc_pkg::WORD_BITS-1];

    // drive decision: diagnostic overrides, then float bit, then chip select
    if (~i_test_n) begin
      next_st.so_oe = 1'b1;
    end else if (st.hiz) begin
      next_st.so_oe = 1'b0;
    end else begin
      next_st.so_oe = selected;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st.link <= ksc_pkg::ksc_idle;
      st.sck_prev <= 1'b0;
      st.cs_prev <= 1'b1;
      st.bit_cnt <= ksc_pkg::CNT_ZERO;
      st.shift_in <= ksc_pkg::RST_WORD;
      st.shift_out <= ksc_pkg::RST_WORD;
      st.last_word <= ksc_pkg::RST_WORD;
      st.so <= 1'b0;
      st.so_oe <= 1'b0;
      st.channel <= ksc_pkg::RST_CHANNEL;
      st.integrate <= 1'b0;
      st.held <= '0;
      st.diag <= 1'b0;
      st.prescaler <= ksc_pkg::RST_PAYLOAD;
      st.hiz <= ksc_pkg::RST_HIZ;
      st.gain <= ksc_pkg::RST_PAYLOAD;
      st.filter <= ksc_pkg::RST_PAYLOAD;
      st.applied <= 1'b0;
      st.frame_err <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign o_so = st.so;
  assign o_so_oe = st.so_oe;
  assign o_channel_sel = st.channel;
  assign o_integrate_mode = st.integrate;
  assign o_integrator_buffered_output = st.held;
  assign o_diag_mode = st.diag;
  assign o_prescaler_code = st.prescaler;
  assign o_prescaler_hiz = st.hiz;
  assign o_gain_code = st.gain;
  assign o_filter_code = st.filter;
  assign o_word_applied = st.applied;
  assign o_frame_error = st.frame_err;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  channel_after_word_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_channel_sel) |-> $past(cs_rise) && $past(word_ok)
      && ($past(cmd) == ksc_pkg::CMD_CHANNEL))
    else $error("channel changed without a complete channel command");

  mode_follows_pin_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_int_hold ##1 i_int_hold |=> o_integrate_mode)
    else $error("integrate mode not following the integrate/hold pin");

  hold_freezes_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !i_int_hold [*3] |-> ##1 $stable(o_integrator_buffered_output)
      && !o_integrate_mode)
    else $error("buffered integrator output moved during hold");

  track_level_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_int_hold |=> o_integrator_buffered_output == $past(i_integrator_level))
    else $error("buffered integrator output not tracking in integrate mode");

  deselect_ignores_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_cs_n |=> $stable(st.shift_in) && $stable(st.bit_cnt))
    else $error("serial state moved while chip select high");

  deselect_floats_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_cs_n && i_test_n |=> !o_so_oe)
    else $error("serial output driven while not selected");

  prog_hiz_wins_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !i_cs_n && i_test_n && o_prescaler_hiz |=> !o_so_oe)
    else $error("serial output driven despite programmed float bit");

  active_enabled_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !i_cs_n && i_test_n && !o_prescaler_hiz |=> o_so_oe)
    else $error("serial output floating while selected and allowed");

  diag_drives_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !i_test_n |=> o_so_oe && o_diag_mode)
    else $error("diagnostic mode did not force the serial output on");

  word_length_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (st.link == ksc_pkg::ksc_shift) && cs_rise
      |=> (o_word_applied == $past(word_ok)) && (o_frame_error == !$past(word_ok)))
    else $error("word accepted or rejected with the wrong bit count");

  capture_fall_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    sck_fall && (st.link == ksc_pkg::ksc_shift) |=> st.shift_in[0] == $past(i_si))
    else $error("serial bit not captured on falling clock edge");

  apply_on_rise_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !cs_rise |=> $stable(o_gain_code) && $stable(o_filter_code)
      && $stable(o_prescaler_code))
    else $error("setting changed outside chip select release");

  frame_start_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (st.link == ksc_pkg::ksc_idle) && cs_fall
      |=> (st.link == ksc_pkg::ksc_shift) && (st.bit_cnt == ksc_pkg::CNT_ZERO)
      && (st.shift_out == $past(st.last_word)))
    else $error("frame start did not clear the count or load the echo");

  normal_mode_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_test_n |=> !o_diag_mode)
    else $error("diagnostic mode while the test input is high");

  hold_mode_pin_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !i_int_hold |=> !o_integrate_mode)
    else $error("integrate mode while the integrate/hold pin is low");

endmodule : ksc_serial_ctrl

// ---- verif/ksc_host.sv ----
// host model: drives chip select, serial clock, serial data and the hold line
// assumes the bench sequences it through its tasks, entered at a falling clk edge
`timescale 1ns/100ps

module ksc_host (
  input wire logic i_clk_sys,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  output logic o_int_hold
);
  // --------------------------------------------------------
  // idle levels and tasks
  // --------------------------------------------------------
  // released data line rests at its pull-up level
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b1;
    o_int_hold = 1'b0;
  end

  // select, then give the part two cycles to see the frame start
  task automatic open_frame();
    @(negedge i_clk_sys);
    o_cs_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
  endtask : open_frame

  // data set with the rise so it is stable across the fall
  task automatic put_bit(input logic b);
    o_si = b;
    o_sck = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    o_sck = 1'b0;
    repeat (2) @(negedge i_clk_sys);
  endtask : put_bit

  task automatic close_frame();
    o_cs_n = 1'b1;
    o_si = 1'b1;
    repeat (3) @(negedge i_clk_sys);
  endtask : close_frame

  task automatic set_hold(input logic v);
    o_int_hold = v;
  endtask : set_hold
endmodule : ksc_host

// ---- verif/knock_processor_serial_control_test.sv ----
// self-checking bench for the knock processor serial control logic
// assumes ksc_host as the serial master; inputs change at falling clk edges
`timescale 1ns/100ps

module knock_processor_serial_control_test;
  typedef struct packed {
    logic err;
    logic chan;
    logic [5:0] pres;
    logic [5:0] gain;
    logic [5:0] filt;
  } ksc_note_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic test_n = 1'b1;
  logic [9:0] level = 10'h000;
  logic cs_n, sck, si, int_hold, so, so_oe, chan, imode, diag, hiz, applied, ferr;
  logic [9:0] held;
  logic [9:0] held_exp;
  logic [5:0] pres, gain, filt;
  ksc_note_type expd = '0;
  ksc_note_type nt;
  ksc_note_type notes[$];
  logic [7:0] last_word = 8'h00;
  logic ok;
  logic diag_exp = 1'b0;
  int errors = 0;
  int n_compared = 0;
  integer seed = 32'h42fc_8883;
  int bad_n[3] = '{0, 7, 9};

  always #5 clk = ~clk;

  ksc_host host_u (.i_clk_sys(clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_int_hold(int_hold));

  ksc_serial_ctrl #(.INTEG_W(10)) dut_u (.i_clk_sys(clk), .i_rst(rst), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .i_int_hold(int_hold), .i_test_n(test_n),
    .i_integrator_level(level), .o_so(so), .o_so_oe(so_oe), .o_channel_sel(chan),
    .o_integrate_mode(imode), .o_integrator_buffered_output(held), .o_diag_mode(diag),
    .o_prescaler_code(pres), .o_prescaler_hiz(hiz), .o_gain_code(gain),
    .o_filter_code(filt), .o_word_applied(applied), .o_frame_error(ferr));

  // --------------------------------------------------------
  // checking and closing
  // --------------------------------------------------------
  task automatic check(input logic c, input string msg);
    n_compared++;
    if (c !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic conclude();
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // oldest note is matched against each frame result pulse
  always @(negedge clk) begin
    if (applied === 1'b1 || ferr === 1'b1) begin
      if (notes.size() == 0) begin
        check(1'b0, "frame result with none expected");
      end else begin
        nt = notes.pop_front();
        ok = ({ferr, chan, pres, gain, filt} === nt) && (applied === ~nt.err);
        ok = ok && (hiz === nt.pres[0]);
        check(ok, "settings after frame");
      end
    end
  end

  // --------------------------------------------------------
  // frame helpers
  // --------------------------------------------------------
  // the echo and the drive enable are checked inside every send8 frame
  task automatic send8(input logic [7:0] w);
    logic echo_ok;
    echo_ok = 1'b1;
    host_u.open_frame();
    check(so_oe === (diag_exp | ~expd.pres[0]), "drive enable while selected");
    check(so === last_word[7], "echo msb");
    // each serial clock fall moves the next echo bit up, zeros follow the last
    for (int i = 7; i >= 0; i--) begin
      host_u.put_bit(w[i]);
      echo_ok = echo_ok & (so === ((i > 0) ? last_word[i-1] : 1'b0));
    end
    check(echo_ok, "echo shifts out msb first");
    case (w[7:6])
      ksc_pkg::CMD_PRESCALER: expd.pres = w[5:0];
      ksc_pkg::CMD_CHANNEL: expd.chan = w[0];
      ksc_pkg::CMD_GAIN: expd.gain = w[5:0];
      default: expd.filt = w[5:0];
    endcase
    notes.push_back(expd);
    last_word = w;
    host_u.close_frame();
    check(so_oe === diag_exp, "drive enable while deselected");
  endtask : send8

  // wrong length: settings stay, an error note is expected
  task automatic bad_frame(input int n);
    host_u.open_frame();
    repeat (n) host_u.put_bit(1'($random(seed)));
    notes.push_back({1'b1, expd[18:0]});
    host_u.close_frame();
  endtask : bad_frame

  // --------------------------------------------------------
  // main sequence
  // --------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(so_oe === 1'b0 && diag === 1'b0, "idle after reset");
    for (int i = 0; i < 8; i++) send8({2'(i), 6'($random(seed))});
    send8({ksc_pkg::CMD_CHANNEL, 6'h01});
    send8({ksc_pkg::CMD_CHANNEL, 6'h00});
    foreach (bad_n[k]) bad_frame(bad_n[k]);
    repeat (8) host_u.put_bit(1'b0);
    send8({ksc_pkg::CMD_PRESCALER, 6'h01});
    send8({ksc_pkg::CMD_GAIN, 6'h2a});
    test_n = 1'b0;
    diag_exp = 1'b1;
    @(negedge clk);
    check(diag === 1'b1 && so_oe === 1'b1, "diagnostic drive");
    send8({ksc_pkg::CMD_FILTER, 6'h15});
    test_n = 1'b1;
    diag_exp = 1'b0;
    @(negedge clk);
    send8({ksc_pkg::CMD_PRESCALER, 6'h3e});
    send8({ksc_pkg::CMD_CHANNEL, 6'h01});
    // integrate tracks one cycle late, hold freezes the last tracked level
    host_u.set_hold(1'b1);
    repeat (4) begin
      level = 10'($random(seed));
      @(negedge clk);
      check(held === level && imode === 1'b1, "integrate tracking");
    end
    held_exp = level;
    ok = 1'b1;
    host_u.set_hold(1'b0);
    repeat (4) begin
      level = ~level;
      @(negedge clk);
      ok = ok & (held === held_exp) & (imode === 1'b0);
    end
    check(ok, "hold freezes output");
    check(notes.size() == 0, "missing frame results");
    conclude();
  end

  // watchdog far beyond the roughly 700 cycles the sequence needs
  initial begin
    #200_000;
    errors++;
    conclude();
  end
endmodule : knock_processor_serial_control_test
